// file: core/seq_decoder_regs.svh
// Offsets, reset values and fixed sizes of the sequencer decode unit.
// Assumes a 12-bit word-addressed host port; included by its bare name.
`ifndef SEQ_DECODER_REGS_SVH
`define SEQ_DECODER_REGS_SVH

// Host port map (word addresses)
`define PATTERN_BASE_SEL 2'h0
`define PROGRAM_BASE_SEL 2'h1
`define LOOP_REG_BASE_SEL 8'h80
`define CONTROL_FLAGS_ADDR 12'h810
`define RUN_FLAG_ADDR 12'h811
`define STATUS_ADDR 12'h812
`define ENABLES_ADDR 12'h813

// Reset values
`define PATTERN_PTR_RESET 10'h000
`define PC_RESET 12'h000
`define CONTROL_FLAGS_RESET 16'h0000
`define OUT_REG_RESET 8'h00

// Bus mode code that writes the enables function register
`define WRITE_MODE_CODE 2'h1

// Depth of the return and loop stacks, and pointer width
`define STACK_DEPTH 16
`define STACK_PTR_WIDTH 5

`endif

// file: core/seq_decoder_pkg.sv
// Types of the sequencer decode unit: opcodes and the decoded instruction.
// Assumes nothing beyond a SystemVerilog compiler.
package seq_decoder_pkg;

    // Opcodes, one nibble each
    typedef enum logic [3:0] {
        no_op = 4'h0,
        pointer_load_op = 4'h1,
        pointer_step_up_op = 4'h2,
        pointer_step_down_op = 4'h3,
        set_device_address_op = 4'h4,
        set_bus_mode_op = 4'h5,
        set_board_select_op = 4'h6,
        loop_open_register_count_op = 4'h7,
        subroutine_call_op = 4'h8,
        subroutine_exit_op = 4'h9,
        branch_on_control_flag_op = 4'hA,
        loop_open_pattern_count_op = 4'hB,
        loop_close_op = 4'hC,
        delay_ms_op = 4'hD,
        delay_us_op = 4'hE,
        delay_tick_op = 4'hF
    } opcode_type;

    // Opcode followed by four operand nibbles
    typedef struct packed {
        opcode_type opcode;
        logic [3:0] nib1;
        logic [3:0] nib2;
        logic [3:0] nib3;
        logic [3:0] nib4;
    } instr_type;

endpackage : seq_decoder_pkg

// file: core/pattern_sequencer_decoder.sv
// Decode and execute unit of the waveform sequencer.
// Assumes core_clk_in is the sequencer tick and the host port is synchronous.
//
// Behaviour
// - 32x1024 pattern store drives whole bus
// - Opcode nibble plus zero to four operands
// - Every instruction completes in one tick
// - 0001b loads 10-bit pattern pointer
// - 0010b increments pattern pointer
// - 0011b decrements pattern pointer
// - 0100b loads 5-bit device address
// - 0101b loads 2-bit bus mode
// - 0110b loads seven encoded select bits
// - Lowest select stays internal, not driven
// - 1000b pushes return, jumps to subroutine
// - 1001b pops return address and jumps
// - 1010b jumps when selected control flag set
// - Register loop open pushes address, count
// - 1011b pushes address and pattern word
// - Loop stacks allow nesting to depth
// - 1100b decrements and loops, or pops
// - Pointer clears on reset, runs only when run
// - Counter advances by length; low bits pick nibble
// - Sixteen 16-bit loop registers host writable
// - Local select plus write mode loads enables
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "seq_decoder_regs.svh"

module pattern_sequencer_decoder
    import seq_decoder_pkg::*;
(
    input wire logic core_clk_in, // Sequencer tick, 10 MHz
    input wire logic rst_in, // Asynchronous reset, active high
    input wire logic [11:0] host_addr_in, // Host word address
    input wire logic [31:0] host_wdata_in, // Host write data
    input wire logic host_wr_in, // Host write strobe
    input wire logic host_rd_in, // Host read strobe
    output logic [31:0] host_rdata_out, // Read data, cycle after strobe
    output logic [31:0] seq_bus_out, // Sequence bus address and data
    output logic [4:0] dev_addr_out, // Bus device address
    output logic [1:0] bus_mode_out, // Bus mode bits
    output logic [6:1] board_select_out, // Backplane board selects
    output logic [31:0] enables_function_register_out // Enables function register
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [31:0] pattern_mem [0:1023]; // Pattern store
    logic [15:0] program_mem [0:1023]; // Program, four nibbles a word
    logic [15:0] loop_regs [0:15]; // Host loaded loop counts
    logic [11:0] return_stack [0:`STACK_DEPTH-1]; // Return addresses
    logic [11:0] loop_addr_stack [0:`STACK_DEPTH-1]; // Loop start addresses
    logic [31:0] loop_count_stack [0:`STACK_DEPTH-1]; // Loop counts

    logic [11:0] pc; // Nibble program counter
    logic [9:0] pattern_ptr; // Pattern pointer
    logic [15:0] control_flags; // Host control register
    logic run_flag; // Sequencer run flag
    logic internal_local_select; // Lowest select bit, internal only
    logic [`STACK_PTR_WIDTH-1:0] ret_sp; // Return stack fill
    logic [`STACK_PTR_WIDTH-1:0] loop_sp; // Loop stack fill

    ////////////////////////////////////////////////////////////////////////////
    // Fetch and decode

    logic [9:0] fetch_word; // Word holding the opcode
    logic [31:0] fetch_window; // Two consecutive program words
    logic [31:0] fetch_shifted; // Opcode aligned to the top
    instr_type instr; // Current instruction
    logic [2:0] instr_len; // Length in nibbles
    logic [11:0] pc_plus; // Address of the following instruction
    logic [11:0] next_pc; // Program counter after this tick
    logic [9:0] next_pattern_ptr; // Pattern pointer after this tick
    logic ret_push; // Push return address
    logic ret_pop; // Pop return address
    logic loop_push; // Push both loop stacks
    logic loop_pop; // Pop both loop stacks
    logic loop_dec; // Decrement top loop count
    logic [31:0] loop_push_count; // Count to push
    logic [3:0] ret_top; // Top index of return stack
    logic [3:0] loop_top; // Top index of loop stacks

    assign ret_top = 4'(ret_sp - 1'b1);
    assign loop_top = 4'(loop_sp - 1'b1);

    // Select the 20 instruction bits by the low counter bits
    always_comb begin
        fetch_word = pc[11:2];
        fetch_window = {program_mem[fetch_word], program_mem[10'(fetch_word + 1'b1)]};
        fetch_shifted = fetch_window << {pc[1:0], 2'b00};
        instr = instr_type'(fetch_shifted[31:12]);
    end

    // Instruction length in nibbles
    always_comb begin
        case (instr.opcode)
            pointer_load_op: instr_len = 3'd4;
            set_device_address_op: instr_len = 3'd3;
            set_bus_mode_op: instr_len = 3'd2;
            set_board_select_op: instr_len = 3'd3;
            loop_open_register_count_op: instr_len = 3'd2;
            subroutine_call_op: instr_len = 3'd4;
            branch_on_control_flag_op: instr_len = 3'd5;
            delay_ms_op: instr_len = 3'd3;
            delay_us_op: instr_len = 3'd3;
            delay_tick_op: instr_len = 3'd3;
            default: instr_len = 3'd1;
        endcase
        pc_plus = pc + 12'(instr_len);
    end

    // Next counter, pointer and stack actions, all in one tick
    always_comb begin
        next_pc = pc_plus;
        next_pattern_ptr = pattern_ptr;
        ret_push = 1'b0;
        ret_pop = 1'b0;
        loop_push = 1'b0;
        loop_pop = 1'b0;
        loop_dec = 1'b0;
        loop_push_count = pattern_mem[pattern_ptr];
        case (instr.opcode)
            // Pattern pointer control
            pointer_load_op: begin
                next_pattern_ptr = {instr.nib1[1:0], instr.nib2, instr.nib3};
            end
            pointer_step_up_op: begin
                next_pattern_ptr = pattern_ptr + 10'h001;
            end
            pointer_step_down_op: begin
                next_pattern_ptr = pattern_ptr - 10'h001;
            end
            // Subroutines
            subroutine_call_op: begin
                ret_push = 1'b1;
                next_pc = {instr.nib1, instr.nib2, instr.nib3};
            end
            subroutine_exit_op: begin
                if (ret_sp != '0) begin
                    ret_pop = 1'b1;
                    next_pc = return_stack[ret_top];
                end
            end
            // Conditional branch, falls through when flag clear
            branch_on_control_flag_op: begin
                if (control_flags[instr.nib1]) begin
                    next_pc = {instr.nib2, instr.nib3, instr.nib4};
                end else begin
                    next_pc = pc_plus;
                end
            end
            // Loops
            loop_open_register_count_op: begin
                loop_push = 1'b1;
                loop_push_count = {16'h0000, loop_regs[instr.nib1]};
            end
            loop_open_pattern_count_op: begin
                loop_push = 1'b1;
            end
            loop_close_op: begin
                if (loop_sp != '0) begin
                    if (loop_count_stack[loop_top] != 32'h0000_0000) begin
                        loop_dec = 1'b1;
                        next_pc = loop_addr_stack[loop_top];
                    end else begin
                        loop_pop = 1'b1;
                    end
                end
            end
            default: begin
                next_pc = pc_plus;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and pattern pointer

    // Counter steps only while running
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc <= `PC_RESET;
        end else if (run_flag) begin
            pc <= next_pc;
        end
    end

    // Pointer clears on reset, moves only while running
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pattern_ptr <= `PATTERN_PTR_RESET;
        end else if (run_flag) begin
            pattern_ptr <= next_pattern_ptr;
        end
    end

    // Whole pattern word drives the bus at once
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seq_bus_out <= 32'h0000_0000;
        end else begin
            // A stopped sequencer keeps showing the word under the pointer
            seq_bus_out <= pattern_mem[run_flag ? next_pattern_ptr : pattern_ptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers, loaded only by their own instruction, except the enables register, loaded on local select plus write mode

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dev_addr_out <= 5'h00;
            bus_mode_out <= 2'h0;
            board_select_out <= 6'h00;
            internal_local_select <= 1'b0;
        end else if (run_flag) begin
            case (instr.opcode)
                set_device_address_op: begin
                    dev_addr_out <= {instr.nib1[0], instr.nib2};
                end
                set_bus_mode_op: begin
                    bus_mode_out <= instr.nib1[1:0];
                end
                set_board_select_op: begin
                    board_select_out <= {instr.nib1[2:0], instr.nib2[3:1]};
                    internal_local_select <= instr.nib2[0];
                end
                default: begin
                    dev_addr_out <= dev_addr_out;
                end
            endcase
        end
    end

    // Enables register takes the current pattern on local write
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            enables_function_register_out <= 32'h0000_0000;
        end else if (internal_local_select && bus_mode_out == `WRITE_MODE_CODE) begin
            enables_function_register_out <= pattern_mem[pattern_ptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stacks

    // Return stack; a push when full is dropped
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ret_sp <= '0;
        end else if (run_flag && ret_push && ret_sp != `STACK_PTR_WIDTH'(`STACK_DEPTH)) begin
            return_stack[ret_sp[3:0]] <= pc_plus;
            ret_sp <= ret_sp + 1'b1;
        end else if (run_flag && ret_pop) begin
            ret_sp <= ret_sp - 1'b1;
        end
    end

    // Loop address and count stacks move together
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_sp <= '0;
        end else if (run_flag) begin
            if (loop_push && loop_sp != `STACK_PTR_WIDTH'(`STACK_DEPTH)) begin
                loop_addr_stack[loop_sp[3:0]] <= pc_plus;
                loop_count_stack[loop_sp[3:0]] <= loop_push_count;
                loop_sp <= loop_sp + 1'b1;
            end else if (loop_dec) begin
                loop_count_stack[loop_top] <= loop_count_stack[loop_top] - 32'h0000_0001;
            end else if (loop_pop) begin
                loop_sp <= loop_sp - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host port

    // Host writes to memories and loop registers
    always_ff @(posedge core_clk_in) begin
        if (host_wr_in) begin
            if (host_addr_in[11:10] == `PATTERN_BASE_SEL) begin
                pattern_mem[host_addr_in[9:0]] <= host_wdata_in;
            end else if (host_addr_in[11:10] == `PROGRAM_BASE_SEL) begin
                program_mem[host_addr_in[9:0]] <= host_wdata_in[15:0];
            end else if (host_addr_in[11:4] == `LOOP_REG_BASE_SEL) begin
                loop_regs[host_addr_in[3:0]] <= host_wdata_in[15:0];
            end
        end
    end

    // Host control flags and run flag
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            control_flags <= `CONTROL_FLAGS_RESET;
            run_flag <= 1'b0;
        end else if (host_wr_in) begin
            if (host_addr_in == `CONTROL_FLAGS_ADDR) begin
                control_flags <= host_wdata_in[15:0];
            end
            if (host_addr_in == `RUN_FLAG_ADDR) begin
                run_flag <= host_wdata_in[0];
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_rdata_out <= 32'h0000_0000;
        end else if (!host_rd_in) begin
            host_rdata_out <= 32'h0000_0000;
        end else if (host_addr_in[11:10] == `PATTERN_BASE_SEL) begin
            host_rdata_out <= pattern_mem[host_addr_in[9:0]];
        end else if (host_addr_in[11:10] == `PROGRAM_BASE_SEL) begin
            host_rdata_out <= {16'h0000, program_mem[host_addr_in[9:0]]};
        end else if (host_addr_in[11:4] == `LOOP_REG_BASE_SEL) begin
            host_rdata_out <= {16'h0000, loop_regs[host_addr_in[3:0]]};
        end else begin
            case (host_addr_in)
                `CONTROL_FLAGS_ADDR: host_rdata_out <= {16'h0000, control_flags};
                `RUN_FLAG_ADDR: host_rdata_out <= {31'h0000_0000, run_flag};
                `STATUS_ADDR: host_rdata_out <= {internal_local_select, ret_sp, loop_sp,
                    pattern_ptr[8:0], pc};
                `ENABLES_ADDR: host_rdata_out <= enables_function_register_out;
                default: host_rdata_out <= 32'h0000_0000; // Unmapped
            endcase
        end
    end

endmodule : pattern_sequencer_decoder

// file: testbench/seq_decoder_properties.sv
// Port-level checker for the sequencer decode unit.
// Assumes the host port map and write mode code of the shared header.
`timescale 1ns/1ps
`include "seq_decoder_regs.svh"

module seq_decoder_properties (
    input wire logic core_clk_in, // Tick
    input wire logic rst_in, // Async reset
    input wire logic [11:0] host_addr_in, // Host address
    input wire logic [31:0] host_wdata_in, // Host data
    input wire logic host_wr_in, // Write strobe
    input wire logic host_rd_in, // Read strobe
    input wire logic [31:0] host_rdata_out, // Read data
    input wire logic [31:0] seq_bus_out, // Pattern word
    input wire logic [4:0] dev_addr_out, // Device address
    input wire logic [1:0] bus_mode_out, // Mode bits
    input wire logic [6:1] board_select_out, // Selects
    input wire logic [31:0] enables_function_register_out // Enables
);
    logic run_q; // Shadow of the run bit
    logic [1:0] settle; // Edges since reset, saturating

    ////////////////////////////////////////////////////////////////////////
    // Shadow run bit from host writes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
        end else if (host_wr_in && host_addr_in == `RUN_FLAG_ADDR) begin
            run_q <= host_wdata_in[0];
        end
    end

    // Settle counter keeps reset values out of stability checks
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence no_read_s; !host_rd_in; endsequence
    sequence unmapped_read_s; host_rd_in && host_addr_in > `ENABLES_ADDR; endsequence
    sequence frozen_s; settle == 2'h3 && !run_q && !$past(run_q); endsequence

    AST_RDATA_IDLE: assert property (no_read_s |=> host_rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED_ZERO: assert property (unmapped_read_s |=> host_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_RESET_OUTPUTS: assert property (settle == 2'h0 |-> dev_addr_out == 5'h00
        && bus_mode_out == 2'h0 && board_select_out == 6'h00)
        else $error("outputs not cleared by reset");
    AST_DEV_HOLD: assert property (frozen_s |-> $stable(dev_addr_out))
        else $error("device address moved while stopped");
    AST_MODE_HOLD: assert property (frozen_s |-> $stable(bus_mode_out))
        else $error("bus mode moved while stopped");
    AST_SELECT_HOLD: assert property (frozen_s |-> $stable(board_select_out))
        else $error("board select moved while stopped");
    AST_BUS_FROZEN: assert property (frozen_s and !$past(host_wr_in, 2)
        |-> $stable(seq_bus_out))
        else $error("pattern word moved while stopped");
    AST_ENABLES_HOLD: assert property ($past(bus_mode_out) != `WRITE_MODE_CODE
        |-> $stable(enables_function_register_out))
        else $error("enables moved without write mode");
endmodule : seq_decoder_properties

bind pattern_sequencer_decoder seq_decoder_properties props (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .host_addr_in(host_addr_in),
    .host_wdata_in(host_wdata_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
    .host_rdata_out(host_rdata_out), .seq_bus_out(seq_bus_out),
    .dev_addr_out(dev_addr_out), .bus_mode_out(bus_mode_out),
    .board_select_out(board_select_out),
    .enables_function_register_out(enables_function_register_out));

// file: testbench/acquisition_boards.sv
// Passive model of the backplane boards on the sequence bus.
// Assumes boards latch the bus word while any backplane select is high.
`timescale 1ns/1ps

module acquisition_boards (
    input wire logic core_clk_in, // Tick
    input wire logic [31:0] seq_bus_in, // Pattern word
    input wire logic [6:1] board_select_in, // Backplane selects only
    output logic [31:0] last_word_out // Word last latched
);
    // Latch when selected; local select never reaches the boards
    always_ff @(posedge core_clk_in) begin
        if (|board_select_in) begin
            last_word_out <= seq_bus_in;
        end
    end
endmodule : acquisition_boards

// file: testbench/tb.sv
// Self-checking bench: loads a program, runs it, checks final state.
// Assumes the host map of the hand-over and a 10 MHz tick.
`timescale 1ns/1ps

module tb;
    logic core_clk_in = 1'b0; // Tick
    logic rst_in = 1'b1; // Reset
    logic [11:0] host_addr_in = 12'h000; // Host address
    logic [31:0] host_wdata_in = 32'h0; // Host data
    logic host_wr_in = 1'b0; // Write strobe
    logic host_rd_in = 1'b0; // Read strobe
    logic [31:0] host_rdata_out, seq_bus_out, enables_out, last_word; // Outputs
    logic [4:0] dev_addr_out; // Device address
    logic [1:0] bus_mode_out; // Mode
    logic [6:1] board_select_out; // Selects
    logic [31:0] pat [0:7]; // Pattern copies
    logic [3:0] prog [0:79]; // Program nibbles
    logic [31:0] exp_q [$]; // Expected read data
    logic rd_seen = 1'b0; // Read taken last edge
    logic [15:0] lr; // Random loop count
    int fails = 0;
    int total_checks = 0;

    pattern_sequencer_decoder uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in), .host_wr_in(host_wr_in),
        .host_rd_in(host_rd_in), .host_rdata_out(host_rdata_out), .seq_bus_out(seq_bus_out),
        .dev_addr_out(dev_addr_out), .bus_mode_out(bus_mode_out),
        .board_select_out(board_select_out), .enables_function_register_out(enables_out));
    acquisition_boards boards (.core_clk_in(core_clk_in), .seq_bus_in(seq_bus_out),
        .board_select_in(board_select_out), .last_word_out(last_word));

    always #50 core_clk_in = ~core_clk_in;

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task stop_test;
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Host write, one cycle
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_addr_in <= a;
        host_wdata_in <= d;
        host_wr_in <= 1'b1;
        host_rd_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : wr

    // Host read, expectation noted
    task rd(input logic [11:0] a, input logic [31:0] e);
        host_addr_in <= a;
        host_wr_in <= 1'b0;
        host_rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_in);
    endtask : rd

    // Release strobes
    task idle(input int n);
        host_wr_in <= 1'b0;
        host_rd_in <= 1'b0;
        repeat (n) @(posedge core_clk_in);
    endtask : idle

    // Place n nibbles, most significant first
    task put(input int at, input logic [19:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            prog[at + i] = v[4 * (n - 1 - i) +: 4];
        end
    endtask : put

    ////////////////////////////////////////////////////////////////////////
    // Read data watcher, one cycle after the strobe
    always @(posedge core_clk_in) rd_seen <= host_rd_in;
    always @(negedge core_clk_in) begin
        if (rd_seen) begin
            check(host_rdata_out, exp_q.pop_front());
        end
    end

    // Watchdog
    initial begin
        repeat (2000) @(posedge core_clk_in);
        fails++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hD74E));
        foreach (prog[i]) prog[i] = 4'h0;
        foreach (pat[i]) pat[i] = $urandom;
        pat[3] = 32'h00000001; // Pattern-count loop count
        lr = $urandom;
        put(8'h00, 20'h1C05, 4);
        put(8'h04, 20'h00023, 2);
        put(8'h06, 20'h4FA, 3);
        put(8'h09, 20'h5E, 2);
        put(8'h0B, 20'h6FB, 3);
        put(8'h0E, 20'h51, 2);
        put(8'h10, 20'h8040, 4);
        put(8'h40, 20'h13FF, 4);
        put(8'h44, 20'h2D009, 5);
        put(8'h14, 20'h50, 2);
        put(8'h16, 20'hA2030, 5);
        put(8'h1B, 20'hA3030, 5);
        put(8'h30, 20'h722C, 4);
        put(8'h34, 20'hB3C, 3);
        put(8'h37, 20'hAF037, 5);
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        for (int i = 0; i < 8; i++) wr(i[11:0], pat[i]);
        rd(12'h812, 32'h0);
        rd(12'h810, 32'h0);
        rd(12'hFFF, 32'h0);
        rd(12'h005, pat[5]);
        for (int w = 0; w < 20; w++) begin
            wr(12'h400 + w[11:0], {16'h0, prog[4*w], prog[4*w+1], prog[4*w+2], prog[4*w+3]});
        end
        wr(12'h802, 32'h00000002);
        wr(12'h80F, {16'h0, lr});
        rd(12'h80F, {16'h0, lr});
        wr(12'h810, 32'h00008008);
        wr(12'h811, 32'h00000001);
        idle(80);
        rd(12'h812, 32'h80001037);
        wr(12'h811, 32'h0);
        idle(4);
        @(negedge core_clk_in);
        check({27'h0, dev_addr_out}, 32'h0000001A);
        check({30'h0, bus_mode_out}, 32'h0);
        check({26'h0, board_select_out}, 32'h0000003D);
        check(enables_out, pat[0]);
        check(seq_bus_out, pat[1]);
        check(last_word, pat[1]);
        stop_test();
    end
endmodule : tb
